// [bench/rstp_board.sv]
// Purpose: board side of the test points: straps and probe
// Assumes: pad enable high while the port drives
// Notes:   a strap only pulls up; an open pad falls to the pulldown
`timescale 1ns/1ns
module rstp_board
	import rstp_pkg::*;
(
	input  wire logic [7:0]  strap_up,
	input  wire logic [7:0]  pad_out,
	input  wire logic [7:0]  pad_oe,
	input  wire logic [7:0]  pull_dn,
	input  wire rstp_flash_t flash_oe,
	output logic      [7:0]  pad_level,
	output logic             prog_ok
);
	// ==========================================================
	// pad resolution
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pad_oe[i])
				pad_level[i] = pad_out[i];
			// only the low three straps are ever fitted
			else if (strap_up[i] && i < 3)
				pad_level[i] = 1'b1;
			else
				pad_level[i] = ~pull_dn[i];
		end
	end
	// ==========================================================
	// flash programmer
	// the programmer may take the flash lines only while the port floats clock, out and select zero; select one is not checked
	assign prog_ok = !(flash_oe.clk || flash_oe.dout || flash_oe.cs0);
endmodule : rstp_board

// [bench/testbench.sv]
// Purpose: self-checking bench for the strap test-point port
// Assumes: inputs change 1 ns after the rising edge
// Notes:   debug clock checks measure half periods in core cycles
`timescale 1ns/1ns
module testbench
	import rstp_pkg::*;
;
	logic        core_clk = 0, rst = 1, ext_reset_low = 0, power_on_request = 0;
	logic [7:0]  strap = 8'h00, pad, tp_o, tp_oe, pull_dn;
	rstp_flash_t fl_pin_out, fl_pin_oe;
	rstp_flash_t fl_core_out = 4'ha, fl_core_oe = 4'hf;
	logic        prog_ok;
	logic        core_released, power_up;
	logic [2:0]  test_mode;
	int          error_cnt = 0, num_checks = 0, cyc = 0;
	always #4 core_clk = ~core_clk;
	rstp_board rstp_board_i (.strap_up(strap), .pad_out(tp_o), .pad_oe(tp_oe),
		.pull_dn(pull_dn), .flash_oe(fl_pin_oe), .pad_level(pad), .prog_ok(prog_ok));
	rstp_port rstp_port_i (.core_clk(core_clk), .rst(rst), .ext_reset_low(ext_reset_low),
		.power_on_request(power_on_request), .test_point_pins_i(pad),
		.test_point_pins_o(tp_o), .test_point_pins_oe(tp_oe), .test_point_pull_dn(pull_dn),
		.flash_core_out(fl_core_out), .flash_core_oe(fl_core_oe), .flash_pin_out(fl_pin_out),
		.flash_pin_oe(fl_pin_oe), .core_released(core_released), .power_up(power_up),
		.test_mode(test_mode));
	// ==========================================================
	// checking and closing
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick
	// a hang counts as a mismatch
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 6000) begin
			error_cnt++;
			results();
		end
	end
	// ==========================================================
	// scenarios
	task automatic release_with(input logic [7:0] s, input logic [2:0] m);
		ext_reset_low = 0;
		strap = s;
		tick(6);
		chk("oe held", tp_oe, 8'h00);
		chk("flash oe held", 8'(fl_pin_oe), 8'h01);
		chk("prog may drive", 8'(prog_ok), 8'h01);
		fl_core_oe = 4'he;
		tick(1);
		chk("cs1 follows core", 8'(fl_pin_oe), 8'h00);
		fl_core_oe = 4'hf;
		tick(1);
		chk("cs1 restored", 8'(fl_pin_oe), 8'h01);
		ext_reset_low = 1;
		for (int i = 0; i < 8 && core_released !== 1'b1; i++)
			tick(1);
		chk("released", 8'(core_released), 8'h01);
		chk("mode", 8'(test_mode), 8'(m));
		tick(1);
		chk("flash oe run", 8'(fl_pin_oe), 8'h0f);
		chk("flash out", 8'(fl_pin_out), 8'h0a);
		chk("prog held off", 8'(prog_ok), 8'h00);
	endtask : release_with
	task automatic t_clkdbg;
		int idx[4] = '{0, 1, 2, 7};
		int n;
		logic b;
		release_with(8'h02, MODE_CLKDBG);
		chk("oe dbg", tp_oe, 8'hff);
		chk("levels", tp_o & 8'h78, 8'h68);
		for (int j = 0; j < 4; j++) begin
			b = tp_o[idx[j]];
			for (int i = 0; i < 20 && tp_o[idx[j]] === b; i++)
				tick(1);
			b = tp_o[idx[j]];
			n = 0;
			for (int i = 0; i < 20 && tp_o[idx[j]] === b; i++) begin
				tick(1);
				n++;
			end
			chk("half period", 8'(n), 8'(DIV_HALF[j]));
		end
		strap = 8'h00;
		tick(10);
		chk("mode kept", 8'(test_mode), 8'(MODE_CLKDBG));
		chk("oe kept", tp_oe, 8'hff);
		$display("test clkdbg done");
	endtask : t_clkdbg
	task automatic t_quiet;
		release_with(8'h00, MODE_QUIET);
		tick(3);
		chk("oe quiet", tp_oe, 8'h00);
		strap = 8'h02;
		tick(10);
		chk("mode after strap change", 8'(test_mode), 8'(MODE_QUIET));
		chk("oe after strap change", tp_oe, 8'h00);
		for (int m = 1; m < 8; m++) begin
			if (m != 2) begin
				release_with(8'(m), 3'(m));
				tick(3);
				chk("oe other", tp_oe, 8'h00);
			end
		end
		$display("test quiet done");
	endtask : t_quiet
	task automatic t_power;
		power_on_request = 1;
		tick(4);
		chk("power up", 8'(power_up), 8'h01);
		power_on_request = 0;
		tick(4);
		chk("power down", 8'(power_up), 8'h00);
		$display("test power done");
	endtask : t_power
	initial begin
		tick(6);
		rst = 0;
		tick(1);
		chk("pulldown", pull_dn, 8'hff);
		t_quiet();
		t_clkdbg();
		t_power();
		results();
	end
endmodule : testbench

// [hw/rstp_port.sv]
// Purpose: test-point strap capture and debug outputs, flash pin release under reset
// Assumes: ext_reset_low and pins are asynchronous to core_clk; rst is power-on reset
// Notes:   debug clocks are core_clk divisions, nearest to the nominal rates
// Functional notes
// - test points are inputs in reset, outputs after only in mode 010
// - straps captured only on reset release edge
// - captured mode holds until next reset cycle
// - internal pulldowns make unstrapped bits zero
// - mode 000 keeps all test points high impedance
// - mode 010 drives debug clocks on 0,1,2,7
// - mode 010 drives 3,5,6 high, 4 low
// - flash clock, out, select zero float in reset
// - power_on_request high powers up, low powers down
`timescale 1ns/1ns
module rstp_port
	import rstp_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        ext_reset_low,
	input  wire logic        power_on_request,
	input  wire logic [7:0]  test_point_pins_i,
	output logic      [7:0]  test_point_pins_o,
	output logic      [7:0]  test_point_pins_oe,
	output logic      [7:0]  test_point_pull_dn,
	input  wire rstp_flash_t flash_core_out,
	input  wire rstp_flash_t flash_core_oe,
	output rstp_flash_t      flash_pin_out,
	output rstp_flash_t      flash_pin_oe,
	output logic             core_released,
	output logic             power_up,
	output logic [2:0]       test_mode
);

	// ==========================================================
	// helpers
	function automatic logic [4:0] div_step(input logic [3:0] cnt, input logic [3:0] half);
		logic [4:0] r;
		r = 5'h00;
		if (cnt + 4'h1 >= half) begin
			r = {4'h0, 1'b1};
		end else begin
			r = {cnt + 4'h1, 1'b0};
		end
		return r;
	endfunction : div_step

	rstp_state_t s_q;
	rstp_state_t s_d;

	// ==========================================================
	// next state
	always_comb begin
		logic [4:0] st;
		st = 5'h00;
		s_d = s_q;
		s_d.rst_s = {s_q.rst_s[1:0], ext_reset_low};
		s_d.pwr_s = {s_q.pwr_s[1:0], power_on_request};
		s_d.tp_s1 = test_point_pins_i;
		s_d.tp_s2 = s_q.tp_s1;
		s_d.tp_s3 = s_q.tp_s2;
		// a level change counts only once the last two stages agree
		if (s_q.rst_s[1] == s_q.rst_s[2]) begin
			s_d.rel = s_q.rst_s[2];
		end
		if (s_q.pwr_s[1] == s_q.pwr_s[2]) begin
			s_d.power_up = s_q.pwr_s[2];
		end
		// pads pull low, so a floating strap reads as zero here
		if (s_d.rel && !s_q.rel) begin
			s_d.mode = s_q.tp_s3[2:0];
		end
		// otherwise mode is untouched until the next release edge
		for (int i = 0; i < 4; i++) begin
			if (s_q.rel && s_q.mode == MODE_CLKDBG) begin
				st = div_step(s_q.cnt[i], DIV_HALF[i]);
				s_d.cnt[i] = st[4:1];
				s_d.div_clk[i] = s_q.div_clk[i] ^ st[0];
			end else begin
				s_d.cnt[i] = 4'h0;
				s_d.div_clk[i] = 1'b0;
			end
		end
		if (s_d.rel && s_d.mode == MODE_CLKDBG) begin
			s_d.tp_oe = TP_ALL_OE;
			s_d.tp_out = {s_d.div_clk[3], 1'b1, 1'b1, 1'b0, 1'b1,
				s_d.div_clk[2], s_d.div_clk[1], s_d.div_clk[0]};
		end else begin
			// quiet and undocumented modes, and all of reset, float the pins
			s_d.tp_oe = TP_NONE;
			s_d.tp_out = TP_NONE;
		end
		s_d.fl_out = flash_core_out;
		s_d.fl_oe = flash_core_oe;
		// select one keeps its own drive so a second device stays deselected
		if (!s_d.rel) begin
			s_d.fl_oe.clk = 1'b0;
			s_d.fl_oe.dout = 1'b0;
			s_d.fl_oe.cs0 = 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// outputs
	assign test_point_pins_o = s_q.tp_out;
	assign test_point_pins_oe = s_q.tp_oe;
	assign test_point_pull_dn = TP_PULLDOWN;
	assign flash_pin_out = s_q.fl_out;
	assign flash_pin_oe = s_q.fl_oe;
	assign core_released = s_q.rel;
	assign power_up = s_q.power_up;
	assign test_mode = s_q.mode;

	// ==========================================================
	// checks
	// enables are registered from the next state, so they move on the same edge as rel
	property p_tp_input_in_reset;
		@(posedge core_clk) disable iff (rst)
		!s_q.rel |-> (test_point_pins_oe == TP_NONE);
	endproperty
	a_tp_input_in_reset: assert property (p_tp_input_in_reset)
		else $error("test points driven while held in reset");

	property p_oe_at_release;
		@(posedge core_clk) disable iff (rst)
		($rose(s_q.rel) && s_q.mode == MODE_CLKDBG) |-> (test_point_pins_oe == TP_ALL_OE);
	endproperty
	a_oe_at_release: assert property (p_oe_at_release)
		else $error("test points not driven after release in clock debug mode");

	property p_capture_value;
		@(posedge core_clk) disable iff (rst)
		$rose(s_q.rel) |-> (s_q.mode == $past(s_q.tp_s3[2:0]));
	endproperty
	a_capture_value: assert property (p_capture_value)
		else $error("mode not captured from straps at release");

	property p_mode_holds;
		@(posedge core_clk) disable iff (rst)
		(s_q.rel && $past(s_q.rel)) || (!s_q.rel) |-> $stable(s_q.mode);
	endproperty
	a_mode_holds: assert property (p_mode_holds)
		else $error("mode changed without a release edge");

	property p_quiet_modes;
		@(posedge core_clk) disable iff (rst)
		(s_q.rel && s_q.mode != MODE_CLKDBG) |-> ##1 (test_point_pins_oe == TP_NONE);
	endproperty
	a_quiet_modes: assert property (p_quiet_modes)
		else $error("test points driven outside clock debug mode");

	property p_dbg_levels;
		@(posedge core_clk) disable iff (rst)
		(test_point_pins_oe == TP_ALL_OE) |-> (test_point_pins_o[3] && !test_point_pins_o[4]
			&& test_point_pins_o[5] && test_point_pins_o[6]);
	endproperty
	a_dbg_levels: assert property (p_dbg_levels)
		else $error("fixed debug levels wrong");

	property p_tp0_clock;
		@(posedge core_clk) disable iff (rst)
		(s_q.rel && s_q.mode == MODE_CLKDBG)[*3] |->
			(test_point_pins_o[0] != $past(test_point_pins_o[0]))
			&& (test_point_pins_oe == TP_ALL_OE);
	endproperty
	a_tp0_clock: assert property (p_tp0_clock)
		else $error("fastest debug clock not toggling every cycle");

	property p_tp1_clock;
		@(posedge core_clk) disable iff (rst)
		(s_q.rel && s_q.mode == MODE_CLKDBG)[*3] |->
			(test_point_pins_o[1] != $past(test_point_pins_o[1], 2));
	endproperty
	a_tp1_clock: assert property (p_tp1_clock)
		else $error("second debug clock not toggling every two cycles");

	property p_flash_float;
		@(posedge core_clk) disable iff (rst)
		!s_q.rel |-> !(flash_pin_oe.clk || flash_pin_oe.dout || flash_pin_oe.cs0);
	endproperty
	a_flash_float: assert property (p_flash_float)
		else $error("flash pins driven during reset");

	property p_flash_run;
		@(posedge core_clk) disable iff (rst)
		s_q.rel |-> (flash_pin_oe == $past(flash_core_oe));
	endproperty
	a_flash_run: assert property (p_flash_run)
		else $error("flash drive not handed back after reset");

	property p_cs1_free;
		@(posedge core_clk) disable iff (rst)
		1'b1 |-> ##1 (flash_pin_oe.cs1 == $past(flash_core_oe.cs1));
	endproperty
	a_cs1_free: assert property (p_cs1_free)
		else $error("select one drive altered");

	property p_power_follow;
		@(posedge core_clk) disable iff (rst)
		(s_q.pwr_s[1] == s_q.pwr_s[2]) |-> ##1 (power_up == $past(s_q.pwr_s[2]));
	endproperty
	a_power_follow: assert property (p_power_follow)
		else $error("power state does not follow request");

	c_release: cover property (@(posedge core_clk) disable iff (rst) $rose(s_q.rel));
	c_clkdbg: cover property (@(posedge core_clk) disable iff (rst)
		s_q.rel && s_q.mode == MODE_CLKDBG && test_point_pins_o[3]);
	c_power_off: cover property (@(posedge core_clk) disable iff (rst) $fell(power_up));
	c_other_mode: cover property (@(posedge core_clk) disable iff (rst)
		$rose(s_q.rel) && s_q.mode != MODE_QUIET && s_q.mode != MODE_CLKDBG);

endmodule : rstp_port

// [inc/rstp_pkg.sv]
// Purpose: shared constants and types for the reset-strap test-point port
// Assumes: core_clk at 125 MHz
// Notes:   debug clock rates are approximated by integer division of core_clk
package rstp_pkg;

	// ==========================================================
	// timing
	localparam int CLK_KHZ = 125000;
	localparam int TP0_KHZ = 60000;
	localparam int TP1_KHZ = 30000;
	localparam int TP2_KHZ = 22500;
	localparam int TP7_KHZ = 7500;

	// half period in core cycles; all but tp2 round down, tp2 rounds up to stay in its band
	localparam int TP0_HALF_I = (CLK_KHZ / (2 * TP0_KHZ) < 1) ? 1 : CLK_KHZ / (2 * TP0_KHZ);
	localparam int TP1_HALF_I = (CLK_KHZ / (2 * TP1_KHZ) < 1) ? 1 : CLK_KHZ / (2 * TP1_KHZ);
	localparam int TP2_HALF_I = (CLK_KHZ + 2 * TP2_KHZ - 1) / (2 * TP2_KHZ);
	localparam int TP7_HALF_I = (CLK_KHZ / (2 * TP7_KHZ) < 1) ? 1 : CLK_KHZ / (2 * TP7_KHZ);

	localparam logic [3:0][3:0] DIV_HALF = {4'(TP7_HALF_I), 4'(TP2_HALF_I),
		4'(TP1_HALF_I), 4'(TP0_HALF_I)};

	// ==========================================================
	// modes and reset values
	localparam logic [2:0] MODE_QUIET  = 3'h0;
	localparam logic [2:0] MODE_CLKDBG = 3'h2;
	localparam logic [7:0] TP_PULLDOWN = 8'hff;
	localparam logic [7:0] TP_ALL_OE   = 8'hff;
	localparam logic [7:0] TP_NONE     = 8'h00;
	localparam logic [2:0] SYNC_RST    = 3'h0;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic clk;
		logic dout;
		logic cs0;
		logic cs1;
	} rstp_flash_t;

	typedef struct packed {
		logic [2:0]      rst_s;
		logic [2:0]      pwr_s;
		logic [7:0]      tp_s1;
		logic [7:0]      tp_s2;
		logic [7:0]      tp_s3;
		logic            rel;
		logic [2:0]      mode;
		logic [3:0][3:0] cnt;
		logic [3:0]      div_clk;
		logic [7:0]      tp_out;
		logic [7:0]      tp_oe;
		rstp_flash_t     fl_out;
		rstp_flash_t     fl_oe;
		logic            power_up;
	} rstp_state_t;

endpackage : rstp_pkg
